// file: cbw_pkg.sv
// Constants and types shared by the card block write and value command handler
package cbw_pkg;
  localparam logic [7:0]  OP_WRITE     = 8'hA0;
  localparam logic [7:0]  OP_DEC       = 8'hC0;
  localparam logic [7:0]  OP_INC       = 8'hC1;
  localparam logic [7:0]  OP_RESTORE   = 8'hC2;
  localparam logic [7:0]  OP_TRANSFER  = 8'hB0;
  localparam logic [3:0]  ACK_CODE     = 4'hA;
  localparam logic [3:0]  NAK_CODE     = 4'h0;
  localparam logic [15:0] CRC_INIT     = 16'h6363;
  localparam int          P1_LEN       = 4;
  localparam int          WR_P2_LEN    = 18;
  localparam int          VAL_P2_LEN   = 6;
  localparam int          FRAME_BYTES  = 18;
  localparam int          CLK_KHZ      = 200000;
  localparam int          FC_KHZ       = 13560;
  localparam int          FDT_N        = 9;
  localparam int          FDT_FC       = FDT_N * 128 + 84;
  localparam int          FDT_CYC      = (FDT_FC * CLK_KHZ + FC_KHZ - 1) / FC_KHZ;
  localparam int          TO_SHORT_US  = 5000;
  localparam int          TO_LONG_US   = 10000;
  localparam int          TO_SHORT_CYC = TO_SHORT_US * (CLK_KHZ / 1000);
  localparam int          TO_LONG_CYC  = TO_LONG_US * (CLK_KHZ / 1000);
  localparam int          CNT_W        = 22;
  typedef enum logic [1:0] {ST_RX, ST_CHECK, ST_DELAY} cbw_state_type;
  typedef enum logic [1:0] {PH_NONE, PH_WRITE, PH_VALUE} cbw_phase_type;
endpackage

// file: cbw_mem.sv
// Block memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cbw_mem #(
  parameter int AW = 8,
  parameter int DW = 128
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end

  assign rdata = rdata_q;
endmodule
`default_nettype wire

// file: cbw_core.sv
// Command handler for block write, increment, decrement, restore and transfer
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Write is two parts, part one answered first
// - Write part two stores sixteen bytes whole
// - Write answers after frame delay, within timeout
// - Increment puts block value plus operand
// - Decrement puts block value minus operand
// - Restore copies block value, ignores operand
// - Value part two carries signed four-byte operand
// - NAK part one on invalid value block
// - Value part one answers after delay, within timeout
// - No answer after value command part two
// - Value commands touch only the transfer buffer
// - Transfer writes buffer into destination block
// - Transfer answers after frame delay, within timeout
// - Block address is a full byte
module cbw_core #(
  parameter int FDT_CYC = cbw_pkg::FDT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_end,
  output logic            tx_valid,
  output logic      [3:0] tx_code
);
  cbw_pkg::cbw_state_type state_q, state_d;
  cbw_pkg::cbw_phase_type phase_q, phase_d;
  logic [7:0]  fr_q [cbw_pkg::FRAME_BYTES];
  logic [7:0]  fr_d [cbw_pkg::FRAME_BYTES];
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] crc_q, crc_d;
  logic [7:0]  op_q, op_d;
  logic [7:0]  wr_adr_q, wr_adr_d;
  logic [31:0] src_val_q, src_val_d;
  logic [7:0]  src_adr_q, src_adr_d;
  logic [31:0] buf_val_q, buf_val_d;
  logic [7:0]  buf_adr_q, buf_adr_d;
  logic        buf_vld_q, buf_vld_d;
  logic [cbw_pkg::CNT_W-1:0] dly_q, dly_d;
  logic [3:0]  code_q, code_d;
  logic        tx_valid_q, tx_valid_d;
  logic [3:0]  tx_code_q, tx_code_d;
  logic        mem_we;
  logic [7:0]  mem_waddr;
  logic [127:0] mem_wdata;
  logic [127:0] mem_rdata;
  logic [127:0] wr_block;
  logic [31:0] operand;
  logic        crc_ok;
  logic        buf_load;

  // Byte-wise update; a frame including its own CRC leaves a zero residue
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [7:0] t;
    t = b ^ c[7:0];
    t = t ^ {t[3:0], 4'h0};
    return {8'h00, c[15:8]} ^ {t, 8'h00} ^ {5'h00, t, 3'h0} ^ {12'h000, t[7:4]};
  endfunction

  function automatic logic blk_is_value(input logic [127:0] b);
    return (b[63:32] == ~b[31:0]) && (b[95:64] == b[31:0]) &&
           (b[119:112] == b[103:96]) && (b[111:104] == ~b[103:96]) &&
           (b[127:120] == ~b[103:96]);
  endfunction

  function automatic logic [127:0] fmt_value(input logic [31:0] v, input logic [7:0] a);
    return {~a, a, ~a, a, v, ~v, v};
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_wr
      assign wr_block[gi*8 +: 8] = fr_q[gi];
    end
  endgenerate

  assign operand = {fr_q[3], fr_q[2], fr_q[1], fr_q[0]};
  assign crc_ok  = (crc_q == 16'h0000);

  cbw_mem #(
    .AW (8),
    .DW (128)
  ) u_mem (
    .clk   (core_clk),
    .nrst  (nrst),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (fr_q[1]),
    .rdata (mem_rdata)
  );

  always_comb begin
    state_d    = state_q;
    phase_d    = phase_q;
    fr_d       = fr_q;
    cnt_d      = cnt_q;
    crc_d      = crc_q;
    op_d       = op_q;
    wr_adr_d   = wr_adr_q;
    src_val_d  = src_val_q;
    src_adr_d  = src_adr_q;
    buf_val_d  = buf_val_q;
    buf_adr_d  = buf_adr_q;
    buf_vld_d  = buf_vld_q;
    dly_d      = dly_q;
    code_d     = code_q;
    tx_valid_d = 1'b0;
    tx_code_d  = tx_code_q;
    mem_we     = 1'b0;
    mem_waddr  = fr_q[1];
    mem_wdata  = fmt_value(buf_val_q, buf_adr_q);
    buf_load   = 1'b0;
    unique case (state_q)
      cbw_pkg::ST_RX: begin
        if (rx_valid) begin
          if (cnt_q < 5'(cbw_pkg::FRAME_BYTES)) begin
            fr_d[cnt_q] = rx_byte;
          end
          if (cnt_q != 5'h1F) begin
            cnt_d = cnt_q + 5'h01;
          end
          crc_d = crc_upd(crc_q, rx_byte);
        end else if (rx_end) begin
          cnt_d = 5'h00;
          crc_d = cbw_pkg::CRC_INIT;
          dly_d = '0;
          unique case (phase_q)
            cbw_pkg::PH_NONE: begin
              // Malformed first parts get silence
              if (cnt_q == 5'(cbw_pkg::P1_LEN) && crc_ok) begin
                op_d = fr_q[0];
                if (fr_q[0] == cbw_pkg::OP_WRITE) begin
                  wr_adr_d = fr_q[1];
                  phase_d  = cbw_pkg::PH_WRITE;
                  code_d   = cbw_pkg::ACK_CODE;
                  state_d  = cbw_pkg::ST_DELAY;
                end else if (fr_q[0] == cbw_pkg::OP_INC || fr_q[0] == cbw_pkg::OP_DEC ||
                             fr_q[0] == cbw_pkg::OP_RESTORE) begin
                  state_d = cbw_pkg::ST_CHECK;
                end else if (fr_q[0] == cbw_pkg::OP_TRANSFER) begin
                  if (buf_vld_q) begin
                    mem_we = 1'b1;
                    code_d = cbw_pkg::ACK_CODE;
                  end else begin
                    code_d = cbw_pkg::NAK_CODE;
                  end
                  state_d = cbw_pkg::ST_DELAY;
                end
              end
            end
            cbw_pkg::PH_WRITE: begin
              phase_d = cbw_pkg::PH_NONE;
              state_d = cbw_pkg::ST_DELAY;
              if (cnt_q == 5'(cbw_pkg::WR_P2_LEN) && crc_ok) begin
                mem_we    = 1'b1;
                mem_waddr = wr_adr_q;
                mem_wdata = wr_block;
                code_d    = cbw_pkg::ACK_CODE;
              end else begin
                code_d = cbw_pkg::NAK_CODE;
              end
            end
            cbw_pkg::PH_VALUE: begin
              // Result lands in the buffer only; no answer follows
              phase_d = cbw_pkg::PH_NONE;
              if (cnt_q == 5'(cbw_pkg::VAL_P2_LEN) && crc_ok) begin
                buf_load  = 1'b1;
                buf_vld_d = 1'b1;
                buf_adr_d = src_adr_q;
                if (op_q == cbw_pkg::OP_INC) begin
                  buf_val_d = src_val_q + operand;
                end else if (op_q == cbw_pkg::OP_DEC) begin
                  buf_val_d = src_val_q - operand;
                end else begin
                  buf_val_d = src_val_q;
                end
              end
            end
            default: begin
              phase_d = cbw_pkg::PH_NONE;
            end
          endcase
        end
      end
      cbw_pkg::ST_CHECK: begin
        state_d = cbw_pkg::ST_DELAY;
        if (blk_is_value(mem_rdata)) begin
          src_val_d = mem_rdata[31:0];
          src_adr_d = mem_rdata[103:96];
          phase_d   = cbw_pkg::PH_VALUE;
          code_d    = cbw_pkg::ACK_CODE;
        end else begin
          phase_d = cbw_pkg::PH_NONE;
          code_d  = cbw_pkg::NAK_CODE;
        end
      end
      cbw_pkg::ST_DELAY: begin
        // Answer lands one frame delay after the frame end, one cycle later via ST_CHECK, far below every timeout
        if (dly_q == cbw_pkg::CNT_W'(FDT_CYC - 1)) begin
          tx_valid_d = 1'b1;
          tx_code_d  = code_q;
          state_d    = cbw_pkg::ST_RX;
        end else begin
          dly_d = dly_q + cbw_pkg::CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= cbw_pkg::ST_RX;
      phase_q    <= cbw_pkg::PH_NONE;
      fr_q       <= '{default: 8'h00};
      cnt_q      <= 5'h00;
      crc_q      <= cbw_pkg::CRC_INIT;
      op_q       <= 8'h00;
      wr_adr_q   <= 8'h00;
      src_val_q  <= 32'h0000_0000;
      src_adr_q  <= 8'h00;
      buf_val_q  <= 32'h0000_0000;
      buf_adr_q  <= 8'h00;
      buf_vld_q  <= 1'b0;
      dly_q      <= '0;
      code_q     <= 4'h0;
      tx_valid_q <= 1'b0;
      tx_code_q  <= 4'h0;
    end else begin
      state_q    <= state_d;
      phase_q    <= phase_d;
      fr_q       <= fr_d;
      cnt_q      <= cnt_d;
      crc_q      <= crc_d;
      op_q       <= op_d;
      wr_adr_q   <= wr_adr_d;
      src_val_q  <= src_val_d;
      src_adr_q  <= src_adr_d;
      buf_val_q  <= buf_val_d;
      buf_adr_q  <= buf_adr_d;
      buf_vld_q  <= buf_vld_d;
      dly_q      <= dly_d;
      code_q     <= code_d;
      tx_valid_q <= tx_valid_d;
      tx_code_q  <= tx_code_d;
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_code  = tx_code_q;

  // Cycles since the last frame end, for timing checks only
  logic [cbw_pkg::CNT_W-1:0] since_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      since_q <= '0;
    end else if (rx_end) begin
      since_q <= '0;
    end else if (since_q != '1) begin
      since_q <= since_q + cbw_pkg::CNT_W'(1);
    end
  end

  a_answer_min_delay: assert property (@(posedge core_clk) disable iff (!nrst)
    tx_valid_q |-> since_q >= cbw_pkg::CNT_W'(FDT_CYC))
    else $error("answer earlier than frame delay");
  a_answer_timeout: assert property (@(posedge core_clk) disable iff (!nrst)
    tx_valid_q |-> since_q <= cbw_pkg::CNT_W'(cbw_pkg::TO_SHORT_CYC))
    else $error("answer later than short timeout");
  a_write_stores: assert property (@(posedge core_clk) disable iff (!nrst)
    (mem_we && phase_q == cbw_pkg::PH_WRITE) |-> mem_waddr == wr_adr_q && mem_wdata == wr_block)
    else $error("write part two stored wrong data");
  a_value_nak: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == cbw_pkg::ST_CHECK && !blk_is_value(mem_rdata)) |=>
    code_q == cbw_pkg::NAK_CODE && phase_q == cbw_pkg::PH_NONE)
    else $error("invalid value block not refused");
  a_inc_sum: assert property (@(posedge core_clk) disable iff (!nrst)
    (buf_load && op_q == cbw_pkg::OP_INC) |=> buf_val_q == $past(src_val_q) + $past(operand))
    else $error("increment result wrong");
  a_dec_diff: assert property (@(posedge core_clk) disable iff (!nrst)
    (buf_load && op_q == cbw_pkg::OP_DEC) |=> buf_val_q == $past(src_val_q) - $past(operand))
    else $error("decrement result wrong");
  a_restore_copy: assert property (@(posedge core_clk) disable iff (!nrst)
    (buf_load && op_q == cbw_pkg::OP_RESTORE) |=> buf_val_q == $past(src_val_q))
    else $error("restore result wrong");
  a_value_silent: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == cbw_pkg::ST_RX && rx_end && phase_q == cbw_pkg::PH_VALUE) |=>
    state_q == cbw_pkg::ST_RX [*2])
    else $error("answer started after value part two");
  a_buf_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !buf_load |=> $stable(buf_val_q) && $stable(buf_adr_q))
    else $error("transfer buffer changed without command");
  a_transfer_data: assert property (@(posedge core_clk) disable iff (!nrst)
    (mem_we && phase_q == cbw_pkg::PH_NONE) |->
    mem_wdata == fmt_value(buf_val_q, buf_adr_q) && mem_waddr == fr_q[1])
    else $error("transfer wrote wrong block content");
  a_no_mem_value: assert property (@(posedge core_clk) disable iff (!nrst)
    buf_load |-> !mem_we)
    else $error("value command wrote memory");
endmodule
`default_nettype wire

// file: cbw_reader.sv
// Reader model that frames commands with CRC and times the card's answers
`timescale 1ns/1ps
`default_nettype none
module cbw_reader #(
  parameter int FDT = 20
) (
  input  wire logic       core_clk,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            rx_end,
  input  wire logic       tx_valid,
  input  wire logic [3:0] tx_code
);
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h5A;
    rx_end   = 1'b0;
  end

  task automatic put(input logic [7:0] v);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_byte  <= v;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_byte  <= ~v; // Idle line never repeats the last byte
  endtask

  // Sends len bytes plus CRC, then times the answer from the end-of-frame edge
  task automatic frame(input logic [7:0] b [18], input int len, input bit bad,
                       output bit got, output logic [3:0] code, output int k);
    logic [15:0] c;
    c = 16'h6363;
    got = 1'b0;
    code = 4'h0;
    k = 0;
    for (int i = 0; i < len; i++) begin
      put(b[i]);
      c = c ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    if (bad) c = ~c;
    put(c[7:0]);
    put(c[15:8]);
    @(posedge core_clk);
    rx_end <= 1'b1;
    @(posedge core_clk);
    rx_end <= 1'b0;
    // Sitting out the whole window also keeps the gap between parts above FDT
    for (int i = 1; i <= FDT + 8; i++) begin
      @(posedge core_clk);
      #1;
      if (tx_valid === 1'b1 && !got) begin
        got  = 1'b1;
        code = tx_code;
        k    = i;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: card_block_write_value_ops_test.sv
// Self-checking bench for the card command handler
`timescale 1ns/1ps
`default_nettype none
module card_block_write_value_ops_test;
  localparam int         FDT  = 20;
  localparam logic [7:0] ACK  = {4'h1, cbw_pkg::ACK_CODE};
  localparam logic [7:0] NAK  = {4'h1, cbw_pkg::NAK_CODE};
  localparam logic [7:0] NONE = 8'h00;
  localparam logic [7:0] VOPS [3] = '{cbw_pkg::OP_INC, cbw_pkg::OP_DEC, cbw_pkg::OP_RESTORE};
  // Block 00 holds 64h and the operand is -2: sum, difference, copy
  localparam logic [31:0] EXPV [3] = '{32'h0000_0062, 32'h0000_0066, 32'h0000_0064};
  logic       core_clk;
  logic       nrst;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       rx_end;
  logic       tx_valid;
  logic [3:0] tx_code;
  logic [7:0] b [18];
  int         miscompares;
  int         compares;

  cbw_core #(.FDT_CYC(FDT)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_end(rx_end), .tx_valid(tx_valid), .tx_code(tx_code));
  cbw_reader #(.FDT(FDT)) rdr_u (
    .core_clk(core_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_end(rx_end), .tx_valid(tx_valid), .tx_code(tx_code));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Sends b[0..len-1]; exp is 1 in the upper nibble plus the code, or NONE
  task automatic run(input int len, input bit bad, input logic [7:0] exp);
    bit         got;
    logic [3:0] code;
    int         k;
    rdr_u.frame(b, len, bad, got, code, k);
    check("answer", exp, got ? {4'h1, code} : NONE);
    if (got) begin
      // Answer sits at the frame delay, far inside every timeout
      check("answer delay", 8'h01, {7'h00, k >= FDT && k <= FDT + 3});
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] exp);
    b[0] = op;
    b[1] = a;
    run(2, 1'b0, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input bit spoil,
                    input bit bad, input logic [7:0] exp2);
    cmd(cbw_pkg::OP_WRITE, a, ACK);
    for (int i = 0; i < 4; i++) begin
      b[i]     = v[8*i+:8];
      b[i + 4] = ~v[8*i+:8];
      b[i + 8] = v[8*i+:8];
    end
    b[12] = a;
    b[13] = ~a;
    b[14] = a;
    b[15] = spoil ? a : ~a;
    run(16, bad, exp2);
  endtask

  task automatic val(input logic [7:0] op, input logic [7:0] a, input logic [31:0] v,
                     input logic [7:0] exp1);
    cmd(op, a, exp1);
    if (exp1 == ACK) begin
      for (int i = 0; i < 4; i++) b[i] = v[8*i+:8];
      run(4, 1'b0, NONE);
    end
  endtask

  task automatic s_fresh;
    cmd(cbw_pkg::OP_TRANSFER, 8'h10, NAK);
  endtask

  task automatic s_write;
    wr(8'h00, 32'h0000_0064, 1'b0, 1'b0, ACK);
    wr(8'hFF, 32'h0000_0064, 1'b1, 1'b0, ACK);
    wr(8'h05, 32'h1234_5678, 1'b1, 1'b0, ACK);
    check("block 05", 32'h1234_5678, dut_u.u_mem.mem_q[8'h05][31:0]);
    val(cbw_pkg::OP_INC, 8'h00, 32'h0000_0001, ACK);
    check("buffer", 32'h0000_0065, dut_u.buf_val_q);
    val(cbw_pkg::OP_INC, 8'hFF, 32'h0000_0001, NAK);
  endtask

  task automatic s_value;
    for (int i = 0; i < 3; i++) begin
      val(VOPS[i], 8'h00, 32'hFFFF_FFFE, ACK);
      check("buffer", EXPV[i], dut_u.buf_val_q);
      check("block 00", 32'h0000_0064, dut_u.u_mem.mem_q[8'h00][31:0]);
      val(cbw_pkg::OP_RESTORE, 8'h05, 32'h0, NAK);
      cmd(cbw_pkg::OP_TRANSFER, 8'h05, ACK);
      check("block 05", EXPV[i], dut_u.u_mem.mem_q[8'h05][31:0]);
      val(cbw_pkg::OP_RESTORE, 8'h05, 32'h0, ACK);
      wr(8'h05, 32'h0000_0001, 1'b1, 1'b0, ACK);
    end
    cmd(cbw_pkg::OP_TRANSFER, 8'h06, ACK);
    check("block 06", 32'h0000_0064, dut_u.u_mem.mem_q[8'h06][31:0]);
    cmd(cbw_pkg::OP_TRANSFER, 8'hFF, ACK);
    val(cbw_pkg::OP_DEC, 8'hFF, 32'h8000_0000, ACK);
    check("buffer", 32'h8000_0064, dut_u.buf_val_q);
  endtask

  task automatic s_crc;
    b[0] = cbw_pkg::OP_INC;
    b[1] = 8'h00;
    run(2, 1'b1, NONE);
    // Unknown opcode with a good CRC is ignored
    b[0] = 8'h5A;
    run(2, 1'b0, NONE);
    wr(8'h00, 32'h0, 1'b1, 1'b1, NAK);
    cmd(cbw_pkg::OP_WRITE, 8'h00, ACK);
    run(15, 1'b0, NAK);
    val(cbw_pkg::OP_RESTORE, 8'h00, 32'h0, ACK);
    cmd(cbw_pkg::OP_INC, 8'h00, ACK);
    run(4, 1'b1, NONE);
    check("buffer", 32'h0000_0064, dut_u.buf_val_q);
  endtask

  task automatic complete_run;
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    miscompares = 0;
    compares = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    s_fresh;
    s_write;
    s_value;
    s_crc;
    complete_run;
  end
endmodule
`default_nettype wire
